// ---- cpia_config_port.sv ----
// Configuration port gate: key state machine, index/data ports, register bank
// ==========================================================
// Function
// - After hard or power-on reset: run state, every logical device disabled.
// - Strap latched at host reset fall or power-on picks port 0x02E or 0x04E.
// - Software relocates the config port via low and high address registers.
// - In run state, writing 0x55 to the config port enters configuration.
// - In configuration, writing 0xAA to the config port returns to run.
// - Index and data ports decode only in configuration state.
// - Index port sits at config port address, data port one above.
// - Index 0x07 then data selects the logical device bank.
// - Index then data reaches a register of the selected logical device.
// - Global registers need no logical device selection.
// - Exactly two states; run accepts the entry key except during the power-on hold-off and hard reset.
// - All host accesses blocked 500 us after power-on reset.
// - Writing one to control register bit 0 soft-resets configuration.
`timescale 1ns/10ps
module cpia_config_port #(
  parameter int NUM_LD = 16,
  parameter int HOLD_CYCLES = cpia_pkg::HOLD_CYCLES,
  parameter logic [7:0] DEV_ID = 8'hC3,   // Arbitrary value
  parameter logic [7:0] DEV_REV = 8'h01   // Arbitrary value
) (
  // Clock and power-on reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Host bus reset and strap
  input wire logic host_bus_reset_n_i,
  input wire logic base_strap_i,
  // Host I/O cycles
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic io_ack_o,
  output logic [7:0] io_rdata_o,
  // Status
  output logic config_mode_o,
  output logic [7:0] ldn_o,
  output logic [15:0] cfg_base_o,
  output logic [NUM_LD-1:0] ld_active_o
);
  localparam int LDW = (NUM_LD > 1) ? $clog2(NUM_LD) : 1;

  // ==========================================================
  // Slot decode
  function automatic logic [3:0] slot_of(input logic [7:0] idx);
    logic [3:0] res;
    res = 4'h0;
    for (int s = 0; s < cpia_pkg::LD_SLOTS; s++) begin
      if (idx == cpia_pkg::SLOT_IDX[s]) begin
        res = {1'b1, 3'(s)};
      end
    end
    return res;
  endfunction

  cpia_pkg::cpia_state_type state_r;
  cpia_pkg::cpia_state_type state_nxt;
  logic [7:0] index_r;
  logic [7:0] index_nxt;
  logic [7:0] ldn_nxt;
  logic [7:0] port_lo_r;
  logic [7:0] port_hi_r;
  logic [7:0] pwr_ctrl_r;
  logic [7:0] pwr_mgmt_r;
  logic [7:0] osc_r;
  logic hr_prev_r;
  logic strap_r;
  logic [7:0] ld_reg_r [NUM_LD][cpia_pkg::LD_SLOTS];
  logic por_blocked;

  cpia_holdoff #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_holdoff (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .blocked_o(por_blocked)
  );

  // ==========================================================
  // Reset and strap handling
  wire hard_rst = ~host_bus_reset_n_i;
  wire hr_fall = hr_prev_r & ~host_bus_reset_n_i;
  wire strap_nxt = hr_fall ? base_strap_i : strap_r;
  wire [7:0] port_lo_rst = strap_nxt ? cpia_pkg::PORT_LO_STRAP1
                                     : cpia_pkg::PORT_LO_STRAP0;
  wire [7:0] por_lo_rst = base_strap_i ? cpia_pkg::PORT_LO_STRAP1
                                       : cpia_pkg::PORT_LO_STRAP0;
  wire any_rst = reset_i | hard_rst;

  // ==========================================================
  // Address decode
  wire blocked = por_blocked | hard_rst;
  wire in_cfg = (state_r == cpia_pkg::CPIA_CFG);
  wire [15:0] base = {port_hi_r, port_lo_r};
  wire hit_index = (io_addr_i == base);
  wire hit_data = in_cfg && (io_addr_i == base + cpia_pkg::DATA_PORT_STEP);
  wire cfg_wr = ~blocked & io_wr_i & hit_index;
  wire data_wr = ~blocked & io_wr_i & hit_data;
  wire index_rd = ~blocked & io_rd_i & hit_index & in_cfg;
  wire data_rd = ~blocked & io_rd_i & hit_data;
  wire is_enter = (io_wdata_i == cpia_pkg::KEY_ENTER);
  wire is_exit = (io_wdata_i == cpia_pkg::KEY_EXIT);
  wire cfg_wr_ok = cfg_wr & (in_cfg | is_enter);
  wire is_global = (index_r < cpia_pkg::IDX_LD_FIRST);
  wire gwr = data_wr & is_global;
  wire soft_rst = gwr & (index_r == cpia_pkg::IDX_CFG_CTRL)
                  & io_wdata_i[cpia_pkg::SOFT_RST_BIT];
  wire [3:0] slot_dec = slot_of(index_r);
  wire [2:0] slot = slot_dec[2:0];
  wire ldn_ok = (ldn_o < 8'(NUM_LD));
  wire [LDW-1:0] ld_sel = ldn_o[LDW-1:0];
  wire ld_wr = data_wr & ~is_global & ldn_ok & slot_dec[3];

  // ==========================================================
  // Next state
  assign state_nxt = (!in_cfg && cfg_wr && is_enter) ? cpia_pkg::CPIA_CFG :
                     (in_cfg && cfg_wr && is_exit) ? cpia_pkg::CPIA_RUN :
                     state_r;
  assign index_nxt = (in_cfg && cfg_wr && !is_exit) ? io_wdata_i : index_r;
  assign ldn_nxt = soft_rst ? cpia_pkg::ZERO_BYTE :
                   (gwr && index_r == cpia_pkg::IDX_LDN) ? io_wdata_i :
                   ldn_o;

  // ==========================================================
  // Read data
  wire [7:0] glob_rdata = (index_r == cpia_pkg::IDX_LDN) ? ldn_o :
                          (index_r == cpia_pkg::IDX_DEV_ID) ? DEV_ID :
                          (index_r == cpia_pkg::IDX_DEV_REV) ? DEV_REV :
                          (index_r == cpia_pkg::IDX_PWR_CTRL) ? pwr_ctrl_r :
                          (index_r == cpia_pkg::IDX_PWR_MGMT) ? pwr_mgmt_r :
                          (index_r == cpia_pkg::IDX_OSC) ? osc_r :
                          (index_r == cpia_pkg::IDX_PORT_LO) ? port_lo_r :
                          (index_r == cpia_pkg::IDX_PORT_HI) ? port_hi_r :
                          cpia_pkg::ZERO_BYTE;
  wire [7:0] ld_rdata = (ldn_ok && slot_dec[3]) ? ld_reg_r[ld_sel][slot]
                                                : cpia_pkg::ZERO_BYTE;
  wire [7:0] data_rdata = is_global ? glob_rdata : ld_rdata;
  wire [7:0] rdata_nxt = index_rd ? index_r : data_rdata;

  // ==========================================================
  // State, index and global registers
  always_ff @(posedge clock_i) begin
    hr_prev_r <= reset_i ? 1'b1 : host_bus_reset_n_i;
    if (reset_i) begin
      strap_r <= base_strap_i;
      port_lo_r <= por_lo_rst;
    end else begin
      strap_r <= strap_nxt;
      port_lo_r <= hard_rst ? port_lo_rst :
                   (gwr && index_r == cpia_pkg::IDX_PORT_LO) ? io_wdata_i : port_lo_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      state_r <= cpia_pkg::CPIA_RUN;
      index_r <= cpia_pkg::ZERO_BYTE;
      ldn_o <= cpia_pkg::ZERO_BYTE;
      port_hi_r <= cpia_pkg::PORT_HI_RST;
      pwr_ctrl_r <= cpia_pkg::ZERO_BYTE;
      pwr_mgmt_r <= cpia_pkg::ZERO_BYTE;
      osc_r <= cpia_pkg::OSC_RST;
    end else begin
      state_r <= state_nxt;
      index_r <= index_nxt;
      ldn_o <= ldn_nxt;
      if (gwr && index_r == cpia_pkg::IDX_PORT_HI) begin
        port_hi_r <= io_wdata_i;
      end
      if (soft_rst) begin
        pwr_ctrl_r <= cpia_pkg::ZERO_BYTE;
      end else if (gwr && index_r == cpia_pkg::IDX_PWR_CTRL) begin
        pwr_ctrl_r <= io_wdata_i;
      end
      if (gwr && index_r == cpia_pkg::IDX_PWR_MGMT) begin
        pwr_mgmt_r <= io_wdata_i;
      end
      if (gwr && index_r == cpia_pkg::IDX_OSC) begin
        osc_r <= io_wdata_i;
      end
    end
  end

  // ==========================================================
  // Host answer and status outputs
  always_ff @(posedge clock_i) begin
    if (any_rst) begin
      io_ack_o <= 1'b0;
      io_rdata_o <= cpia_pkg::ZERO_BYTE;
      config_mode_o <= 1'b0;
      cfg_base_o <= {cpia_pkg::PORT_HI_RST, cpia_pkg::PORT_LO_STRAP0};
    end else begin
      io_ack_o <= cfg_wr_ok | data_wr | index_rd | data_rd;
      io_rdata_o <= (index_rd | data_rd) ? rdata_nxt : cpia_pkg::ZERO_BYTE;
      config_mode_o <= (state_nxt == cpia_pkg::CPIA_CFG);
      cfg_base_o <= base;
    end
  end

  // ==========================================================
  // Logical device banks
  for (genvar g = 0; g < NUM_LD; g++) begin : g_ld
    for (genvar s = 0; s < cpia_pkg::LD_SLOTS; s++) begin : g_slot
      always_ff @(posedge clock_i) begin
        if (any_rst) begin
          ld_reg_r[g][s] <= cpia_pkg::SLOT_RST[s];
        end else if (soft_rst && s == 0) begin
          ld_reg_r[g][s] <= cpia_pkg::ZERO_BYTE;
        end else if (ld_wr && ld_sel == LDW'(g) && slot == 3'(s)) begin
          ld_reg_r[g][s] <= io_wdata_i;
        end
      end
    end
    // Activate bit is read straight from its bank flop
    assign ld_active_o[g] = ld_reg_r[g][0][cpia_pkg::ACT_BIT];
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_after_reset: assert property ($past(reset_i) |->
      !config_mode_o && ld_active_o == '0 && state_r == cpia_pkg::CPIA_RUN)
    else $error("not in run state with devices off after reset");
  a_strap_base: assert property ($past(reset_i) |->
      port_lo_r == ($past(base_strap_i) ? cpia_pkg::PORT_LO_STRAP1 : cpia_pkg::PORT_LO_STRAP0))
    else $error("strap did not pick the config port");
  a_port_reloc: assert property (gwr && index_r == cpia_pkg::IDX_PORT_LO && !hard_rst
      |=> ##1 cfg_base_o[7:0] == $past(io_wdata_i, 2))
    else $error("config port low byte not relocated");
  a_entry_key: assert property (!in_cfg && cfg_wr && is_enter
      |=> config_mode_o && io_ack_o)
    else $error("entry key did not enter configuration");
  a_exit_key: assert property (in_cfg && cfg_wr && is_exit && !hard_rst
      |=> !config_mode_o ##1 !in_cfg)
    else $error("exit key did not leave configuration");
  a_run_no_data: assert property (!in_cfg && io_wr_i && !hit_index
      && io_addr_i == base + cpia_pkg::DATA_PORT_STEP |=> !io_ack_o)
    else $error("data port answered in run state");
  a_data_read: assert property (in_cfg && io_rd_i && !blocked
      && io_addr_i == base + cpia_pkg::DATA_PORT_STEP |=> io_ack_o)
    else $error("data port one above index not decoded");
  a_ldn_select: assert property (gwr && index_r == cpia_pkg::IDX_LDN && !hard_rst
      |=> ldn_o == $past(io_wdata_i))
    else $error("logical device number not stored");
  a_act_route: assert property (ld_wr && index_r == cpia_pkg::IDX_LD_FIRST && !hard_rst
      |=> ld_active_o[$past(ld_sel)] == $past(io_wdata_i[0]))
    else $error("data write did not reach selected bank");
  a_global_id: assert property (data_rd && index_r == cpia_pkg::IDX_DEV_ID
      && !hard_rst |=> io_rdata_o == DEV_ID)
    else $error("global register unreachable");
  a_two_states: assert property ($onehot(state_r))
    else $error("access state not one of two");
  a_block_window: assert property (por_blocked && (io_wr_i || io_rd_i)
      |=> !io_ack_o)
    else $error("access answered during hold-off");
  a_soft_reset: assert property (soft_rst && !hard_rst
      |=> ldn_o == cpia_pkg::ZERO_BYTE && ld_active_o == '0)
    else $error("soft reset did not clear configuration");
  a_index_store: assert property (in_cfg && cfg_wr && !is_exit && !hard_rst
      |=> index_r == $past(io_wdata_i) && config_mode_o)
    else $error("index byte not stored");
  a_hard_block: assert property (hard_rst && (io_wr_i || io_rd_i)
      |=> !io_ack_o && !config_mode_o)
    else $error("access answered during hard reset");
  a_hard_strap: assert property (hr_fall |=> port_lo_r ==
      ($past(base_strap_i) ? cpia_pkg::PORT_LO_STRAP1 : cpia_pkg::PORT_LO_STRAP0))
    else $error("strap not latched at host reset fall");
  a_run_ignore: assert property (!in_cfg && cfg_wr && !is_enter
      |=> !io_ack_o && !config_mode_o)
    else $error("run state answered a non-key byte");
  a_run_no_index: assert property (!in_cfg && io_rd_i && hit_index
      |=> !io_ack_o)
    else $error("index port read answered in run state");
  a_index_read: assert property (index_rd |=> io_ack_o
      && io_rdata_o == $past(index_r))
    else $error("index port read did not return the index");
  a_global_rev: assert property (data_rd && index_r == cpia_pkg::IDX_DEV_REV
      |=> io_rdata_o == DEV_REV)
    else $error("revision register unreachable");
  a_cfg_hold: assert property (in_cfg && !(cfg_wr && is_exit) && !hard_rst
      |=> in_cfg)
    else $error("configuration state left without exit key");
  a_run_hold: assert property (!in_cfg && !(cfg_wr && is_enter)
      |=> !in_cfg)
    else $error("run state left without entry key");
  a_bank_read: assert property (data_rd && !is_global && !ldn_ok
      |=> io_ack_o && io_rdata_o == cpia_pkg::ZERO_BYTE)
    else $error("absent logical device returned data");
  a_rdata_quiet: assert property (!index_rd && !data_rd
      |=> io_rdata_o == cpia_pkg::ZERO_BYTE)
    else $error("read data left standing outside a read");

  c_enter: cover property (!in_cfg && cfg_wr && is_enter);
  c_exit: cover property (in_cfg && cfg_wr && is_exit);
  c_ld_write: cover property (ld_wr);
  c_soft_reset: cover property (soft_rst);
  c_hard_fall: cover property (hr_fall);
endmodule

// ---- cpia_holdoff.sv ----
// Shared constants and the power-on access hold-off counter
`timescale 1ns/10ps
package cpia_pkg;
  // ==========================================================
  // Keys and index map
  localparam logic [7:0] KEY_ENTER = 8'h55;
  localparam logic [7:0] KEY_EXIT = 8'hAA;
  localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_DEV_ID = 8'h20;
  localparam logic [7:0] IDX_DEV_REV = 8'h21;
  localparam logic [7:0] IDX_PWR_CTRL = 8'h22;
  localparam logic [7:0] IDX_PWR_MGMT = 8'h23;
  localparam logic [7:0] IDX_OSC = 8'h24;
  localparam logic [7:0] IDX_PORT_LO = 8'h26;
  localparam logic [7:0] IDX_PORT_HI = 8'h27;
  localparam logic [7:0] IDX_LD_FIRST = 8'h30;
  localparam logic [15:0] DATA_PORT_STEP = 16'h0001;
  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] PORT_LO_STRAP0 = 8'h2E;
  localparam logic [7:0] PORT_LO_STRAP1 = 8'h4E;
  localparam logic [7:0] PORT_HI_RST = 8'h00;
  localparam logic [7:0] OSC_RST = 8'h04;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int SOFT_RST_BIT = 0;
  localparam int ACT_BIT = 0;
  // ==========================================================
  // Per logical device register slots
  localparam int LD_SLOTS = 8;
  localparam logic [7:0] SLOT_IDX [LD_SLOTS] = '{8'h30, 8'h60, 8'h61, 8'h70,
                                                 8'h74, 8'hF0, 8'hF1, 8'hF2};
  localparam logic [7:0] SLOT_RST [LD_SLOTS] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                                 8'h00, 8'h00, 8'h00, 8'h00};
  // ==========================================================
  // Timing
  localparam int HOLD_TIME_US = 500;
  localparam int CLK_FREQ_MHZ = 10;
  localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_FREQ_MHZ;
  // ==========================================================
  // Access state machine
  typedef enum logic [1:0] {
    CPIA_RUN = 2'b01,
    CPIA_CFG = 2'b10
  } cpia_state_type;
endpackage

module cpia_holdoff #(
  parameter int HOLD_CYCLES = cpia_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Status
  output logic blocked_o
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic blocked_nxt;

  assign blocked_nxt = (count_r != CW'(HOLD_CYCLES - 1));
  assign count_nxt = blocked_nxt ? count_r + CW'(1) : count_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_r <= '0;
      blocked_o <= 1'b1;
    end else begin
      count_r <= count_nxt;
      blocked_o <= blocked_nxt;
    end
  end
endmodule

// ---- cpia_host_model.sv ----
// Host model issuing single-byte I/O cycles toward the configuration gate
`timescale 1ns/10ps
module cpia_host_model (
  // Clock
  input wire logic clock_i,
  // I/O cycle request
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [15:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  // Answer
  input wire logic io_ack_i,
  input wire logic [7:0] io_rdata_i
);
  initial begin
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_addr_o = 16'hFFFF;
    io_wdata_o = 8'hFF;
  end
  // ==========================================================
  // One request pulse; the registered answer is taken in the next cycle
  task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] data,
                        output logic ack, output logic [7:0] rdata);
    @(posedge clock_i);
    #5;
    io_wr_o = wr;
    io_rd_o = ~wr;
    io_addr_o = addr;
    io_wdata_o = data;
    @(posedge clock_i);
    #5;
    ack = io_ack_i;
    rdata = io_rdata_i;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    // Released lines show the inverse so a stale value cannot pass for a held one
    io_addr_o = ~addr;
    io_wdata_o = ~data;
  endtask
endmodule

// ---- cpia_config_port_bench.sv ----
// Self-checking bench for the configuration port gate
`timescale 1ns/10ps
module cpia_config_port_bench;
  localparam int HOLD = 8;
  localparam int NLD = 16;
  localparam logic [7:0] DEV_ID = 8'h5A;  // Arbitrary value
  localparam logic [7:0] DEV_REV = 8'h02;  // Arbitrary value
  logic clock_i, reset_i, host_bus_reset_n_i, base_strap_i;
  logic io_wr, io_rd, io_ack, ack, config_mode;
  logic [15:0] io_addr, cfg_base;
  logic [7:0] io_wdata, io_rdata, ldn, rd, rnd;
  logic [NLD-1:0] ld_active;
  int miscompares, samples_checked;
  int m_cfg, m_idx, m_ldn, m_base, m_blk;
  int m_reg[int];
  int lds[4] = '{0, 3, 15, 17};
  int glb[8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h03};

  cpia_config_port #(.NUM_LD(NLD), .HOLD_CYCLES(HOLD), .DEV_ID(DEV_ID), .DEV_REV(DEV_REV)) dut (
    .clock_i(clock_i), .reset_i(reset_i), .host_bus_reset_n_i(host_bus_reset_n_i),
    .base_strap_i(base_strap_i), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_addr_i(io_addr),
    .io_wdata_i(io_wdata), .io_ack_o(io_ack), .io_rdata_o(io_rdata),
    .config_mode_o(config_mode), .ldn_o(ldn), .cfg_base_o(cfg_base), .ld_active_o(ld_active));
  cpia_host_model host (.clock_i(clock_i), .io_wr_o(io_wr), .io_rd_o(io_rd), .io_addr_o(io_addr),
    .io_wdata_o(io_wdata), .io_ack_i(io_ack), .io_rdata_i(io_rdata));

  // ==========================================================
  // Reference model
  function automatic int m_get(int k);
    return m_reg.exists(k) ? m_reg[k] : 0;
  endfunction
  task automatic m_reset(input int strap);
    m_cfg = 0;
    m_idx = 0;
    m_ldn = 0;
    m_reg.delete();
    m_reg[8'h24] = 8'h04;
    m_reg[8'h26] = strap ? 8'h4E : 8'h2E;
    m_base = m_get(8'h26);
  endtask
  function automatic int m_read(int i);
    if (i == 8'h07) return m_ldn;
    if (i == 8'h20) return DEV_ID;
    if (i == 8'h21) return DEV_REV;
    if (i >= 8'h30) return (m_ldn < NLD) ? m_get(256 * (m_ldn + 1) + i) : 0;
    return (i inside {8'h22, 8'h23, 8'h24, 8'h26, 8'h27}) ? m_get(i) : 0;
  endfunction
  task automatic m_write(input int i, input int d);
    if (i == 8'h02 && d[0]) begin
      m_ldn = 0;
      m_reg[8'h22] = 0;
      for (int l = 0; l < NLD; l++) m_reg[256 * (l + 1) + 8'h30] = 0;
    end
    if (i == 8'h07) m_ldn = d;
    if (i inside {8'h22, 8'h23, 8'h24, 8'h26, 8'h27}) m_reg[i] = d;
    for (int s = 0; s < cpia_pkg::LD_SLOTS; s++) begin
      if (i == cpia_pkg::SLOT_IDX[s] && m_ldn < NLD) m_reg[256 * (m_ldn + 1) + i] = d;
    end
    m_base = m_get(8'h27) * 256 + m_get(8'h26);
  endtask
  task automatic m_access(input logic wr, input int a, input int d, output int ea, output int er);
    ea = 0;
    er = 0;
    if (m_blk) return;
    if (m_cfg == 0) begin
      if (wr && a == m_base && d == 8'h55) begin
        ea = 1;
        m_cfg = 1;
      end
    end else if (a == m_base) begin
      ea = 1;
      if (!wr) er = m_idx;
      else if (d == 8'hAA) m_cfg = 0;
      else m_idx = d;
    end else if (a == m_base + 1) begin
      ea = 1;
      if (!wr) er = m_read(m_idx);
      else m_write(m_idx, d);
    end
  endtask

  // ==========================================================
  // Comparisons
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic chk_access(input int ea, input int er);
    cmp("io_ack_o", ea, 32'(ack));
    cmp("io_rdata_o", er, 32'(rd));
  endtask
  task automatic chk_status();
    logic [NLD-1:0] v;
    for (int l = 0; l < NLD; l++) v[l] = 1'(m_get(256 * (l + 1) + 8'h30));
    cmp("config_mode_o", m_cfg, 32'(config_mode));
    cmp("ldn_o", m_ldn & 8'hFF, 32'(ldn));
    cmp("cfg_base_o", m_base, 32'(cfg_base));
    cmp("ld_active_o", 32'(v), 32'(ld_active));
  endtask
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int ea, er;
    m_access(wr, a, d, ea, er);
    host.access(wr, a, d, ack, rd);
    chk_access(ea, er);
    @(posedge clock_i);
    #5;
    chk_status();
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Stimulus
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    #(5000 * 100);
    miscompares++;
    test_done();
  end
  initial begin
    reset_i = 1'b1;
    host_bus_reset_n_i = 1'b1;
    base_strap_i = 1'b0;
    rnd = 8'h4F;
    m_reset(0);
    m_blk = 1;
    repeat (20) @(posedge clock_i);
    #5 reset_i = 1'b0;
    io(1'b1, 16'h002E, 8'h55);
    repeat (HOLD + 2) @(posedge clock_i);
    m_blk = 0;
    io(1'b1, 16'h002E, 8'h07);
    io(1'b0, 16'h002E, 8'h00);
    io(1'b0, 16'h002F, 8'h00);
    io(1'b1, 16'h002F, 8'h01);
    io(1'b1, 16'h002E, 8'h55);
    io(1'b1, 16'h002E, 8'h55);
    io(1'b0, 16'h002E, 8'h00);
    foreach (glb[g]) begin
      io(1'b1, 16'h002E, 8'(glb[g]));
      io(1'b0, 16'h002F, 8'h00);
    end
    foreach (lds[n]) begin
      io(1'b1, 16'h002E, 8'h07);
      io(1'b1, 16'h002F, 8'(lds[n]));
      for (int s = 0; s < cpia_pkg::LD_SLOTS; s++) begin
        rnd = lfsr(rnd);
        io(1'b1, 16'h002E, cpia_pkg::SLOT_IDX[s]);
        io(1'b1, 16'h002F, rnd);
        io(1'b0, 16'h002F, 8'h00);
      end
    end
    io(1'b1, 16'h002E, 8'h07);
    io(1'b1, 16'h002F, 8'h00);
    io(1'b1, 16'h002E, 8'h60);
    io(1'b0, 16'h002F, 8'h00);
    for (int g = 2; g < 5; g++) begin
      rnd = lfsr(rnd);
      io(1'b1, 16'h002E, 8'(glb[g]));
      io(1'b1, 16'h002F, rnd);
    end
    io(1'b1, 16'h002E, 8'h02);
    io(1'b1, 16'h002F, 8'h01);
    foreach (glb[g]) begin
      io(1'b1, 16'h002E, 8'(glb[g]));
      io(1'b0, 16'h002F, 8'h00);
    end
    io(1'b1, 16'h002E, 8'h26);
    io(1'b1, 16'h002F, 8'h4E);
    io(1'b1, 16'h004E, 8'h27);
    io(1'b1, 16'h004F, 8'h01);
    io(1'b0, 16'h014E, 8'h00);
    io(1'b1, 16'h002E, 8'hAA);
    io(1'b1, 16'h014E, 8'hAA);
    io(1'b0, 16'h014F, 8'h00);
    base_strap_i = 1'b1;
    host_bus_reset_n_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #5 host_bus_reset_n_i = 1'b1;
    m_reset(1);
    repeat (2) @(posedge clock_i);
    #5 chk_status();
    io(1'b1, 16'h004E, 8'h55);
    io(1'b1, 16'h004E, 8'hAA);
    test_done();
  end
endmodule
